/* adc_ready_pkg.sv */
// Behaviour
// - Bit 4 sets after a current-sense measurement; clears on main trigger rising.
// - Bit 3 sets when all active pin channels measured; clears on aux trigger rising.
// - Bit 1 sets after one full misc round robin; clears on aux trigger rising.
// - Bit 0 sets after full main round robin; clears on main trigger rising.
package adc_ready_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ready_flags_index  = 12'h527;
    localparam logic [13:0] ready_flags_addr   = 14'h149c;
    localparam logic [13:0] cell_sel_addr      = 14'h14a0;
    localparam logic [13:0] trigger_addr       = 14'h14a4;
    localparam int          addr_w             = 14;
    localparam logic [7:0]  ready_flags_reset  = 8'h00;
    localparam logic [4:0]  cell_sel_reset     = 5'h00;
    localparam logic [1:0]  resp_okay          = 2'h0;
    localparam logic [1:0]  resp_slverr        = 2'h2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int bit_primary  = 0;
    localparam int bit_aux_misc = 1;
    localparam int bit_aux_cell = 2;
    localparam int bit_aux_pin  = 3;
    localparam int bit_cs       = 4;
    localparam int bit_trig_main = 0;
    localparam int bit_trig_aux  = 1;

endpackage : adc_ready_pkg

/* ready_flag_if.sv */
`timescale 1ns/100ps
interface ready_flag_if;
    logic set;
    logic clr;
    logic flag;
    modport owner (input set, input clr, output flag);
    modport user  (output set, output clr, input flag);
endinterface : ready_flag_if

/* ready_flag.sv */
`timescale 1ns/100ps
module ready_flag (
    input wire logic      aclk,    // Clock.
    input wire logic      aresetn, // Synchronous reset, active low.
    ready_flag_if.owner   f        // Set, clear and flag.
);
    typedef struct packed {
        logic flag;
    } st_s;

    st_s st_r;
    st_s st_nxt;

    // A set in the same cycle as a clear wins over the clear.
    always_comb begin
        st_nxt = st_r;
        if (f.clr) begin
            st_nxt.flag = 1'b0;
        end
        if (f.set) begin
            st_nxt.flag = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign f.flag = st_r.flag;
endmodule : ready_flag

/* adc_conversion_ready_status.sv */
`timescale 1ns/100ps
module adc_conversion_ready_status #(
    parameter int main_channels = 24,
    parameter int misc_channels = 8,
    parameter int pin_channels  = 8,
    parameter int cell_channels = 16
) (
    input  wire logic                      aclk,           // Clock, 25 MHz.
    input  wire logic                      aresetn,        // Synchronous reset.
    input  wire logic                      cs_meas_done,   // Current-sense result pulse.
    input  wire logic                      main_meas_done, // Main result pulse.
    input  wire logic [7:0]                main_meas_ch,   // Main channel index.
    input  wire logic                      aux_meas_done,  // Aux result pulse.
    input  wire logic [1:0]                aux_meas_kind,  // 0 misc, 1 pin, 2 cell.
    input  wire logic [7:0]                aux_meas_ch,    // Aux channel index.
    input  wire logic [pin_channels-1:0]   pin_active,     // Pins set for conversion.
    input  wire logic [adc_ready_pkg::addr_w-1:0] s_axi_awaddr, // Write address.
    input  wire logic                      s_axi_awvalid,  // Write address valid.
    output logic                           s_axi_awready,  // Write address ready.
    input  wire logic [31:0]               s_axi_wdata,    // Write data.
    input  wire logic [3:0]                s_axi_wstrb,    // Write strobes.
    input  wire logic                      s_axi_wvalid,   // Write data valid.
    output logic                           s_axi_wready,   // Write data ready.
    output logic [1:0]                     s_axi_bresp,    // Write response.
    output logic                           s_axi_bvalid,   // Write response valid.
    input  wire logic                      s_axi_bready,   // Write response ready.
    input  wire logic [adc_ready_pkg::addr_w-1:0] s_axi_araddr, // Read address.
    input  wire logic                      s_axi_arvalid,  // Read address valid.
    output logic                           s_axi_arready,  // Read address ready.
    output logic [31:0]                    s_axi_rdata,    // Read data.
    output logic [1:0]                     s_axi_rresp,    // Read response.
    output logic                           s_axi_rvalid,   // Read data valid.
    input  wire logic                      s_axi_rready    // Read data ready.
);
    localparam int addr_w_c = adc_ready_pkg::addr_w;

    // The coverage vectors are fixed at 256 and 32 bits, so larger counts cannot be served.
    if (main_channels < 1 || main_channels > 256 || misc_channels < 1
        || misc_channels > 256 || pin_channels < 1 || pin_channels > 32
        || cell_channels < 1 || cell_channels > 32) begin : g_bad_counts
        $error("adc_conversion_ready_status: channel counts out of range");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                     awready;
        logic                     wready;
        logic                     aw_got;
        logic                     w_got;
        logic [addr_w_c-1:0]      awaddr;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     arready;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
        logic [4:0]               cell_sel;
        logic [1:0]               trig;
        logic [255:0]             main_seen;
        logic [255:0]             misc_seen;
        logic [31:0]              pin_seen;
        logic [31:0]              cell_seen;
    } st_s;

    st_s st_r;
    st_s st_nxt;

    ready_flag_if f_cs ();
    ready_flag_if f_pin ();
    ready_flag_if f_cell ();
    ready_flag_if f_misc ();
    ready_flag_if f_main ();

    ready_flag u_cs   (.aclk(aclk), .aresetn(aresetn), .f(f_cs));
    ready_flag u_pin  (.aclk(aclk), .aresetn(aresetn), .f(f_pin));
    ready_flag u_cell (.aclk(aclk), .aresetn(aresetn), .f(f_cell));
    ready_flag u_misc (.aclk(aclk), .aresetn(aresetn), .f(f_misc));
    ready_flag u_main (.aclk(aclk), .aresetn(aresetn), .f(f_main));

    // Mask of the low n bits of a 256-bit vector.
    function automatic logic [255:0] low_mask(input int n);
        logic [255:0] m;
        m = '0;
        for (int i = 0; i < 256; i++) begin
            if (i < n) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : low_mask

    // Cell selection picks the lowest sel+1 channels, limited to the count.
    function automatic logic [31:0] cell_mask(input logic [4:0] sel);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 32; i++) begin
            if (i <= int'(sel) && i < cell_channels) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : cell_mask

    logic [255:0] main_need;
    logic [255:0] misc_need;
    logic [31:0]  pin_need;
    logic [31:0]  cell_need;
    logic         main_rise;
    logic         aux_rise;
    logic [7:0]   flags;
    logic [addr_w_c-1:0] wa;
    logic [31:0]  wd;

    assign main_need = low_mask(main_channels);
    assign misc_need = low_mask(misc_channels);
    assign pin_need  = 32'(pin_active);
    assign cell_need = cell_mask(st_r.cell_sel);
    assign flags     = {3'h0, f_cs.flag, f_pin.flag, f_cell.flag, f_misc.flag, f_main.flag};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt   = st_r;
        wa       = st_r.aw_got ? st_r.awaddr : s_axi_awaddr;
        wd       = st_r.w_got ? st_r.wdata : s_axi_wdata;
        main_rise = 1'b0;
        aux_rise  = 1'b0;

        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.awaddr  = s_axi_awaddr;
            st_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.wdata  = s_axi_wdata;
            st_nxt.wstrb  = s_axi_wstrb;
            st_nxt.wready = 1'b0;
        end
        if (st_nxt.aw_got && st_nxt.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = adc_ready_pkg::resp_okay;
            wa = st_nxt.awaddr;
            wd = st_nxt.wdata;
            if (wa == adc_ready_pkg::cell_sel_addr) begin
                if (st_nxt.wstrb[0]) begin
                    st_nxt.cell_sel = wd[4:0];
                end
            end else if (wa == adc_ready_pkg::trigger_addr) begin
                // Trigger bits are software levels; only a 0 to 1 change clears.
                if (st_nxt.wstrb[0]) begin
                    st_nxt.trig = wd[1:0];
                    main_rise = wd[adc_ready_pkg::bit_trig_main]
                              && !st_r.trig[adc_ready_pkg::bit_trig_main];
                    aux_rise  = wd[adc_ready_pkg::bit_trig_aux]
                              && !st_r.trig[adc_ready_pkg::bit_trig_aux];
                end
            end else if (wa != adc_ready_pkg::ready_flags_addr) begin
                st_nxt.bresp = adc_ready_pkg::resp_slverr;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid  = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready  = 1'b1;
        end

        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid  = 1'b1;
            st_nxt.rresp   = adc_ready_pkg::resp_okay;
            case (s_axi_araddr)
                adc_ready_pkg::ready_flags_addr: st_nxt.rdata = 32'(flags);
                adc_ready_pkg::cell_sel_addr:    st_nxt.rdata = 32'(st_r.cell_sel);
                adc_ready_pkg::trigger_addr:     st_nxt.rdata = 32'(st_r.trig);
                default: begin
                    st_nxt.rdata = 32'h0;
                    st_nxt.rresp = adc_ready_pkg::resp_slverr;
                end
            endcase
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid  = 1'b0;
            st_nxt.arready = 1'b1;
        end

        // Channel coverage; a trigger rise restarts the sweep it owns.
        if (main_rise) begin
            st_nxt.main_seen = '0;
        end
        if (aux_rise) begin
            st_nxt.misc_seen = '0;
            st_nxt.pin_seen  = '0;
            st_nxt.cell_seen = '0;
        end
        if (main_meas_done) begin
            st_nxt.main_seen[main_meas_ch] = 1'b1;
        end
        if (aux_meas_done) begin
            case (aux_meas_kind)
                2'h0: st_nxt.misc_seen[aux_meas_ch] = 1'b1;
                2'h1: st_nxt.pin_seen[aux_meas_ch[4:0]] = 1'b1;
                2'h2: st_nxt.cell_seen[aux_meas_ch[4:0]] = 1'b1;
                default: ;
            endcase
        end
    end

    assign f_cs.clr   = main_rise;
    assign f_main.clr = main_rise;
    assign f_pin.clr  = aux_rise;
    assign f_cell.clr = aux_rise;
    assign f_misc.clr = aux_rise;
    assign f_cs.set   = cs_meas_done;
    assign f_main.set = ((st_r.main_seen & main_need) == main_need) && !main_rise;
    assign f_misc.set = ((st_r.misc_seen & misc_need) == misc_need) && !aux_rise;
    assign f_pin.set  = ((st_r.pin_seen & pin_need) == pin_need) && !aux_rise;
    assign f_cell.set = ((st_r.cell_seen & cell_need) == cell_need) && !aux_rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r         <= '0;
            st_r.awready <= 1'b1;
            st_r.wready  <= 1'b1;
            st_r.arready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
endmodule : adc_conversion_ready_status

/* adc_ready_sva.sv */
`timescale 1ns/100ps
module adc_ready_sva (
    input wire logic        aclk,          // Clock.
    input wire logic        aresetn,       // Reset, active low.
    input wire logic        cs_meas_done,  // Current-sense pulse.
    input wire logic [13:0] s_axi_awaddr,  // Write address.
    input wire logic        s_axi_awvalid, // Write address valid.
    input wire logic        s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata,   // Write data.
    input wire logic [3:0]  s_axi_wstrb,   // Write strobes.
    input wire logic        s_axi_wvalid,  // Write data valid.
    input wire logic        s_axi_wready,  // Write data ready.
    input wire logic [1:0]  s_axi_bresp,   // Write response.
    input wire logic        s_axi_bvalid,  // Write response valid.
    input wire logic        s_axi_bready,  // Write response ready.
    input wire logic [13:0] s_axi_araddr,  // Read address.
    input wire logic        s_axi_arvalid, // Read address valid.
    input wire logic        s_axi_arready, // Read address ready.
    input wire logic [31:0] s_axi_rdata,   // Read data.
    input wire logic [1:0]  s_axi_rresp,   // Read response.
    input wire logic        s_axi_rvalid,  // Read data valid.
    input wire logic        s_axi_rready   // Read data ready.
);
    // ------------------------------------------------------------------
    // Helper model
    // ------------------------------------------------------------------
    // The model commits a trigger write at its response, so it assumes reads do not overlap it.
    logic [13:0] rd_addr_r, wr_addr_r;
    logic        wr_bit_r, wr_en_r, trig_r, cs_r;
    logic        flags_rd, mapped;
    assign flags_rd = s_axi_rvalid && rd_addr_r == adc_ready_pkg::ready_flags_addr;
    assign mapped = s_axi_araddr inside {adc_ready_pkg::ready_flags_addr,
        adc_ready_pkg::cell_sel_addr, adc_ready_pkg::trigger_addr};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr_r <= '0;
            wr_addr_r <= '0;
            wr_bit_r  <= 1'b0;
            wr_en_r   <= 1'b0;
            trig_r    <= 1'b0;
            cs_r      <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
            if (s_axi_awvalid && s_axi_awready) wr_addr_r <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) begin
                wr_bit_r <= s_axi_wdata[0];
                wr_en_r  <= s_axi_wstrb[0];
            end
            if (s_axi_bvalid && s_axi_bready && wr_en_r
                && wr_addr_r == adc_ready_pkg::trigger_addr) begin
                trig_r <= wr_bit_r;
                if (wr_bit_r && !trig_r) cs_r <= 1'b0;
            end
            if (cs_meas_done) cs_r <= 1'b1;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && !mapped |=>
        s_axi_rresp == adc_ready_pkg::resp_slverr && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_reserved_zero: assert property (flags_rd |-> s_axi_rdata[31:5] == 27'h0)
        else $error("reserved flag bits set");
    a_cs_flag: assert property (flags_rd |-> s_axi_rdata[4] == cs_r)
        else $error("current-sense flag wrong");
endmodule : adc_ready_sva

/* adc_conversion_ready_status_tb.sv */
`timescale 1ns/100ps
module adc_conversion_ready_status_tb;
    typedef struct {logic [2:0] src; logic [7:0] ch; logic [7:0] exp;} row_s;
    logic aclk = 1'b0, aresetn = 1'b0, cs_meas_done = 1'b0, main_meas_done = 1'b0;
    logic aux_meas_done = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  main_meas_ch = 8'h00, aux_meas_ch = 8'h00;
    logic [1:0]  aux_meas_kind = 2'h0, s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  pin_active = 4'h5, s_axi_wstrb = 4'hf;
    logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    int          n_fail = 0, total_checks = 0, cycles = 0;
    // Source 0 current sense, 1 main, 2 misc, 3 pin, 4 cell; pins 0 and 2 active, cells 0..1.
    row_s rows [11] = '{'{3'h0, 8'h00, 8'h10}, '{3'h1, 8'h00, 8'h10}, '{3'h1, 8'h01, 8'h10},
        '{3'h1, 8'h02, 8'h10}, '{3'h1, 8'h03, 8'h11}, '{3'h2, 8'h00, 8'h11},
        '{3'h2, 8'h01, 8'h13}, '{3'h3, 8'h00, 8'h13}, '{3'h3, 8'h02, 8'h1b},
        '{3'h4, 8'h00, 8'h1b}, '{3'h4, 8'h01, 8'h1f}};
    adc_conversion_ready_status #(.main_channels(4), .misc_channels(2), .pin_channels(4),
        .cell_channels(4)) u_adc_conversion_ready_status (.aclk, .aresetn, .cs_meas_done,
        .main_meas_done, .main_meas_ch, .aux_meas_done, .aux_meas_kind, .aux_meas_ch,
        .pin_active, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    always #20 aclk = ~aclk;
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Handshakes are judged at the falling edge, where registered outputs have settled.
    task automatic axi_write(input logic [13:0] a, input logic [31:0] v);
        logic aw_hs, w_hs, b_hs;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b_hs = 1'b0;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (b_hs) s_axi_bready <= 1'b0;
        end
        check("write_resp", {30'h0, r}, {30'h0, adc_ready_pkg::resp_okay});
    endtask : axi_write
    task automatic axi_read(input logic [13:0] a);
        logic ar_hs, r_hs;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r_hs = 1'b0;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (r_hs) s_axi_rready <= 1'b0;
        end
    endtask : axi_read
    task automatic rd_flags(input logic [7:0] exp);
        axi_read(adc_ready_pkg::ready_flags_addr);
        check("flags", d, {24'h0, exp});
        check("flags_resp", {30'h0, r}, {30'h0, adc_ready_pkg::resp_okay});
    endtask : rd_flags
    task automatic pulse(input logic [2:0] src, input logic [7:0] ch);
        @(posedge aclk);
        cs_meas_done <= (src == 3'h0);
        main_meas_done <= (src == 3'h1);
        aux_meas_done <= (src > 3'h1);
        aux_meas_kind <= 2'(src - 3'h2);
        main_meas_ch <= ch;
        aux_meas_ch <= ch;
        @(posedge aclk);
        cs_meas_done <= 1'b0;
        main_meas_done <= 1'b0;
        aux_meas_done <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : pulse
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd_flags(adc_ready_pkg::ready_flags_reset);
        axi_write(adc_ready_pkg::cell_sel_addr, 32'h1);
        axi_write(adc_ready_pkg::trigger_addr, 32'h3);
        foreach (rows[i]) begin
            pulse(rows[i].src, rows[i].ch);
            rd_flags(rows[i].exp);
        end
        axi_write(adc_ready_pkg::ready_flags_addr, 32'h0);
        rd_flags(8'h1f);
        axi_write(adc_ready_pkg::trigger_addr, 32'h2);
        rd_flags(8'h1f);
        axi_write(adc_ready_pkg::trigger_addr, 32'h3);
        rd_flags(8'h0e);
        axi_write(adc_ready_pkg::trigger_addr, 32'h1);
        axi_write(adc_ready_pkg::trigger_addr, 32'h3);
        rd_flags(8'h00);
        pulse(3'h2, 8'h00);
        rd_flags(8'h00);
        pulse(3'h2, 8'h01);
        rd_flags(8'h02);
        pulse(3'h0, 8'h00);
        rd_flags(8'h12);
        // A reset in mid-run must drop every flag, the current-sense one included.
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_flags(adc_ready_pkg::ready_flags_reset);
        axi_read(14'h0000);
        check("unmapped_resp", {30'h0, r}, {30'h0, adc_ready_pkg::resp_slverr});
        check("unmapped_data", d, 32'h0);
        test_done();
    end
endmodule : adc_conversion_ready_status_tb
bind adc_conversion_ready_status adc_ready_sva u_adc_ready_sva (.aclk, .aresetn, .cs_meas_done,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
